// file: design/serr_lock_bridge.sv
// system-error reporting and downstream lock forwarding of a two-port bridge
// assumes transaction events arrive as one-cycle pulses from bridge logic on mclk;
// the two error lines and downstream serr are pins and are synchronised here
// Behaviour
// - posted write far-bus parity error, not seen as target, both enables: serr
// - upstream serr never asserts without the command serr enable
// - every serr assertion sets the signaled-system-error status flag
// - downstream serr with forward enable raises serr and sets received flag
// - target or master abort on a posted write is a serr cause
// - retries counted per transaction; limit discards data and raises serr
// - delayed master timeout is a serr cause gated by its own enable
// - cause register records which event raised serr
// - disable bits stop parity, abort and retry events from raising serr
// - upstream and downstream lock states are independent
// - lock high in address phase, asserted one clock later
// - only downstream locks are forwarded; upstream lock ignored
// - initial locked request retried if a lock exists or target bus locked
// - first locked command must be memory read; others master abort
// - locked read queued: queue no more downstream requests, retry them; upstream still queued
// - locked read driven with lock one cycle late; waits for idle release
// - matching repeat returns data and lock held on primary side
// - master timeout discards read, raises serr, releases target lock
// - later locked transactions driven locked on the target bus
// - abort on locked read returns status, no lock, unlocked forwarding resumes
module serr_lock_bridge (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // register port
    input wire logic [serr_lock_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [serr_lock_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [serr_lock_pkg::DATA_W-1:0] reg_rdata,
    // pins
    input wire logic upstream_parity_error_line_n,
    input wire logic downstream_parity_error_line_n,
    input wire logic downstream_system_error_in_n,
    output logic upstream_system_error_out_n,
    output logic upstream_system_error_out_oe,
    // posted write delivery events
    input wire logic pw_active,
    input wire logic pw_upstream,
    input wire logic pw_perr_as_target,
    input wire logic pw_target_abort,
    input wire logic pw_master_abort,
    // retry and timeout events
    input wire logic txn_start,
    input wire logic txn_retry,
    input wire logic txn_done,
    input wire logic dt_master_timeout,
    // downstream locked request from the primary side
    input wire logic req_valid,
    input wire logic req_lock,
    input wire logic req_downstream,
    input wire logic [3:0] req_cmd,
    input wire logic [35:0] req_key,
    input wire logic sec_lock_busy,
    input wire logic sec_bus_idle,
    input wire logic head_is_locked,
    input wire logic tgt_data_done,
    input wire logic tgt_abort,
    input wire logic pri_lock_release,
    // answers to the bridge logic
    output logic req_retry,
    output logic req_master_abort,
    output logic req_queue,
    output logic req_give_data,
    output logic req_give_abort,
    output logic no_prefetch,
    output logic discard,
    output logic sec_lock_drive,
    output logic sec_lock_oe
);
    import serr_lock_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    always_ff @(posedge mclk) begin
        if (srst) begin
            sync1_reg <= 3'h7;
            sync2_reg <= 3'h7;
        end else begin
            sync1_reg <= {downstream_system_error_in_n, downstream_parity_error_line_n,
                          upstream_parity_error_line_n};
            sync2_reg <= sync1_reg;
        end
    end
    wire up_perr = ~sync2_reg[0];
    wire dn_perr = ~sync2_reg[1];
    wire dn_serr = ~sync2_reg[2];

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [15:0] command_reg;
    logic [15:0] bridge_ctrl_reg;
    logic [EV_W-1:0] evt_disable_reg;
    logic [EV_W-1:0] cause_reg;
    logic sig_serr_reg;
    logic rcv_serr_reg;
    logic [RETRY_W-1:0] retry_cnt_reg;
    logic serr_reg;
    // lock state is declared here because the timeout cause reads it
    lock_state_t lk_reg;
    lock_state_t lk_next;
    logic lk_timeout;

    wire wr_cmd = reg_wr && reg_addr == OFS_COMMAND;
    wire wr_pst = reg_wr && reg_addr == OFS_PRI_STATUS;
    wire wr_bc = reg_wr && reg_addr == OFS_BRIDGE_CTRL;
    wire wr_sst = reg_wr && reg_addr == OFS_SEC_STATUS;
    wire wr_cause = reg_wr && reg_addr == OFS_CAUSE;
    wire wr_dis = reg_wr && reg_addr == OFS_EVT_DISABLE;

    // ----------------------------------------
    // error events
    // ----------------------------------------
    wire both_perr_en = command_reg[CMD_PERR_RESP] && bridge_ctrl_reg[BC_PERR_RESP];
    wire far_perr = pw_upstream ? up_perr : dn_perr;
    wire retry_limit = txn_retry && (retry_cnt_reg == RETRY_W'(RETRY_LIMIT - 1));
    logic [EV_W-1:0] ev_raw;
    logic [EV_W-1:0] ev_gated;
    assign ev_raw[EV_PAR] = pw_active && far_perr && !pw_perr_as_target && both_perr_en;
    assign ev_raw[EV_TABORT] = pw_active && pw_target_abort;
    assign ev_raw[EV_MABORT] = pw_active && pw_master_abort;
    assign ev_raw[EV_RETRY] = retry_limit;
    assign ev_raw[EV_MTO] = (dt_master_timeout || lk_timeout) && bridge_ctrl_reg[BC_MTO_SERR_EN];
    assign ev_raw[EV_FWD] = dn_serr && bridge_ctrl_reg[BC_SERR_FWD];
    // the timeout and forward causes have no disable bit
    wire [EV_W-1:0] dis_mask = evt_disable_reg & 6'h0f;
    assign ev_gated = ev_raw & ~dis_mask & {EV_W{command_reg[CMD_SERR_EN]}};
    wire serr_fire = |ev_gated;
    assign discard = retry_limit || lk_timeout;

    always_ff @(posedge mclk) begin
        if (srst) begin
            retry_cnt_reg <= '0;
        end else if (txn_start || txn_done || retry_limit) begin
            retry_cnt_reg <= '0;
        end else if (txn_retry) begin
            retry_cnt_reg <= retry_cnt_reg + RETRY_W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            command_reg <= COMMAND_RST;
            bridge_ctrl_reg <= BRIDGE_CTRL_RST;
            evt_disable_reg <= EVT_DISABLE_RST;
            cause_reg <= '0;
            sig_serr_reg <= 1'b0;
            rcv_serr_reg <= 1'b0;
            serr_reg <= 1'b0;
        end else begin
            serr_reg <= serr_fire;
            if (wr_cmd) command_reg <= reg_wdata[15:0];
            if (wr_bc) bridge_ctrl_reg <= reg_wdata[15:0];
            if (wr_dis) evt_disable_reg <= reg_wdata[EV_W-1:0];
            // write one to clear; a new event wins
            cause_reg <= (cause_reg & ~(wr_cause ? reg_wdata[EV_W-1:0] : '0))
                | ev_gated;
            sig_serr_reg <= (sig_serr_reg && !(wr_pst && reg_wdata[PST_SIG_SERR]))
                || serr_fire;
            rcv_serr_reg <= (rcv_serr_reg && !(wr_sst && reg_wdata[SST_RCV_SERR]))
                || ev_raw[EV_FWD];
        end
    end
    assign upstream_system_error_out_n = 1'b0;
    assign upstream_system_error_out_oe = serr_reg;

    // ----------------------------------------
    // downstream lock tracking
    // ----------------------------------------
    logic [35:0] key_reg;
    logic lk_drive_reg;
    logic lk_delay_reg;
    // aborted locked read waiting for the initiator's repeat
    logic abt_reg;
    assign lk_timeout = dt_master_timeout && lk_reg == LK_TARGET;

    // upstream locked requests never reach this path: req_downstream gates them
    wire lk_req = req_valid && req_lock && req_downstream;
    wire abort_hit = lk_req && abt_reg && req_key == key_reg;
    wire first_req = lk_req && lk_reg == LK_IDLE && !abort_hit;
    wire first_ok = req_cmd == CMD_MEM_READ;
    wire repeat_hit = lk_req && lk_reg == LK_TARGET && req_key == key_reg;
    wire can_issue = head_is_locked && !sec_lock_busy && sec_bus_idle;

    assign req_master_abort = first_req && !first_ok;
    // secondary already locked by another master means retry without forwarding
    wire first_retry = first_req && first_ok && sec_lock_busy;
    wire cross_block = req_valid && req_downstream && !repeat_hit
        && lk_reg != LK_IDLE && lk_reg != LK_HELD;
    assign req_retry = first_retry || cross_block || (req_valid && lk_req && lk_reg == LK_QUEUED);
    assign req_queue = (first_req && first_ok && !sec_lock_busy)
        || (req_valid && req_downstream && lk_reg == LK_HELD)
        || (req_valid && !req_downstream);
    assign req_give_data = repeat_hit && !tgt_abort;
    assign req_give_abort = (repeat_hit && tgt_abort) || abort_hit;
    assign no_prefetch = lk_reg != LK_IDLE;

    always_comb begin
        lk_next = lk_reg;
        unique case (lk_reg)
            LK_IDLE: if (first_req && first_ok && !sec_lock_busy) lk_next = LK_QUEUED;
            LK_QUEUED: if (tgt_abort) lk_next = LK_IDLE;
                else if (tgt_data_done) lk_next = LK_TARGET;
            LK_TARGET: if (lk_timeout || req_give_abort) lk_next = LK_IDLE;
                else if (req_give_data) lk_next = LK_HELD;
            LK_HELD: if (pri_lock_release) lk_next = LK_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            lk_reg <= LK_IDLE;
            key_reg <= '0;
            lk_delay_reg <= 1'b0;
            lk_drive_reg <= 1'b0;
            abt_reg <= 1'b0;
        end else begin
            lk_reg <= lk_next;
            // the abort status stays until the initiator repeats the read
            abt_reg <= (abt_reg && !abort_hit) || (lk_reg == LK_QUEUED && tgt_abort);
            if (first_req && first_ok) key_reg <= req_key;
            // address phase with lock released, asserted the next cycle
            lk_delay_reg <= lk_reg == LK_QUEUED && can_issue;
            lk_drive_reg <= (lk_drive_reg || lk_delay_reg) && lk_next != LK_IDLE
                && !(lk_reg == LK_QUEUED && tgt_abort);
        end
    end
    assign sec_lock_drive = 1'b0;
    assign sec_lock_oe = lk_drive_reg;

    // ----------------------------------------
    // register read port
    // ----------------------------------------
    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        unique case (reg_addr)
            OFS_COMMAND: rd_mux = {16'h0000, command_reg};
            OFS_PRI_STATUS: rd_mux = 32'(sig_serr_reg) << PST_SIG_SERR;
            OFS_BRIDGE_CTRL: rd_mux = {16'h0000, bridge_ctrl_reg};
            OFS_SEC_STATUS: rd_mux = 32'(rcv_serr_reg) << SST_RCV_SERR;
            OFS_CAUSE: rd_mux = 32'(cause_reg);
            OFS_EVT_DISABLE: rd_mux = 32'(evt_disable_reg);
            OFS_LOCK_STATUS: rd_mux = 32'(lk_reg);
            default: rd_mux = '0;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (srst) reg_rdata <= '0;
        else reg_rdata <= reg_rd ? rd_mux : '0;
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_serr_en;
        @(posedge mclk) disable iff (srst)
        upstream_system_error_out_oe |-> $past(command_reg[CMD_SERR_EN]);
    endproperty
    a_serr_en: assert property (p_serr_en) else $error("serr without enable");
    property p_sig_flag;
        @(posedge mclk) disable iff (srst)
        upstream_system_error_out_oe |-> sig_serr_reg;
    endproperty
    a_sig_flag: assert property (p_sig_flag) else $error("status flag missing");
    property p_fwd;
        @(posedge mclk) disable iff (srst)
        ev_raw[EV_FWD] && command_reg[CMD_SERR_EN] |=> upstream_system_error_out_oe && rcv_serr_reg;
    endproperty
    a_fwd: assert property (p_fwd) else $error("forwarded serr lost");
    property p_par;
        @(posedge mclk) disable iff (srst)
        ev_raw[EV_PAR] && command_reg[CMD_SERR_EN] && !evt_disable_reg[EV_PAR]
        |=> upstream_system_error_out_oe && cause_reg[EV_PAR];
    endproperty
    a_par: assert property (p_par) else $error("parity serr lost");
    property p_disable;
        @(posedge mclk) disable iff (srst)
        evt_disable_reg[EV_TABORT] |-> !ev_gated[EV_TABORT];
    endproperty
    a_disable: assert property (p_disable) else $error("disabled event raised");
    property p_cause;
        @(posedge mclk) disable iff (srst)
        serr_fire |=> cause_reg != '0;
    endproperty
    a_cause: assert property (p_cause) else $error("cause not recorded");
    property p_lock_late;
        @(posedge mclk) disable iff (srst)
        $rose(sec_lock_oe) |-> $past(lk_delay_reg);
    endproperty
    a_lock_late: assert property (p_lock_late) else $error("lock driven too early");
    property p_first;
        @(posedge mclk) disable iff (srst)
        first_req && req_cmd != CMD_MEM_READ |-> req_master_abort && !req_queue;
    endproperty
    a_first: assert property (p_first) else $error("bad first locked command");
    property p_timeout;
        @(posedge mclk) disable iff (srst)
        lk_timeout |-> discard ##1 lk_reg == LK_IDLE ##1 !sec_lock_oe;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout kept lock");
endmodule : serr_lock_bridge

// file: design/serr_lock_pkg.sv
// constants for the bridge system-error and lock forwarding block
// assumes a single 40 MHz bus clock and a synchronous active-high reset
package serr_lock_pkg;
    localparam int unsigned CLK_MHZ = 40;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;
    // register offsets (word index of a plain port)
    localparam logic [3:0] OFS_COMMAND = 4'h0;
    localparam logic [3:0] OFS_PRI_STATUS = 4'h1;
    localparam logic [3:0] OFS_BRIDGE_CTRL = 4'h2;
    localparam logic [3:0] OFS_SEC_STATUS = 4'h3;
    localparam logic [3:0] OFS_CAUSE = 4'h4;
    localparam logic [3:0] OFS_EVT_DISABLE = 4'h5;
    localparam logic [3:0] OFS_LOCK_STATUS = 4'h6;
    // command register bits
    localparam int unsigned CMD_PERR_RESP = 6;
    localparam int unsigned CMD_SERR_EN = 8;
    // bridge control bits
    localparam int unsigned BC_PERR_RESP = 0;
    localparam int unsigned BC_SERR_FWD = 1;
    localparam int unsigned BC_MTO_SERR_EN = 11;
    // status bits
    localparam int unsigned PST_SIG_SERR = 14;
    localparam int unsigned SST_RCV_SERR = 14;
    // cause / disable bit positions
    localparam int unsigned EV_PAR = 0;
    localparam int unsigned EV_TABORT = 1;
    localparam int unsigned EV_MABORT = 2;
    localparam int unsigned EV_RETRY = 3;
    localparam int unsigned EV_MTO = 4;
    localparam int unsigned EV_FWD = 5;
    localparam int unsigned EV_W = 6;
    // reset values
    localparam logic [15:0] COMMAND_RST = 16'h0000;
    localparam logic [15:0] BRIDGE_CTRL_RST = 16'h0000;
    localparam logic [EV_W-1:0] EVT_DISABLE_RST = 6'h00;
    // retry limit: two to the twenty-fourth attempts
    localparam int unsigned RETRY_LIMIT = 16777216;
    localparam int unsigned RETRY_W = 25;
    // pci command codes
    localparam logic [3:0] CMD_MEM_READ = 4'h6;
    typedef enum logic [3:0] {
        LK_IDLE = 4'b0001,
        LK_QUEUED = 4'b0010,
        LK_TARGET = 4'b0100,
        LK_HELD = 4'b1000
    } lock_state_t;
endpackage : serr_lock_pkg

// file: tb/sec_bus_model.sv
// secondary bus model: a second master that may hold the lock, and the locked target
// assumes the bridge drives the secondary lock line low while sec_lock_oe is high
module sec_bus_model (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // bridge side
    input wire logic sec_lock_oe,
    output logic sec_lock_busy,
    output logic sec_bus_idle,
    output logic tgt_data_done,
    output logic tgt_abort,
    // scenario controls
    input wire logic other_lock,
    input wire logic abort_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    logic oe_reg;
    logic [2:0] cnt_reg;
    assign sec_bus_idle = (cnt_reg == 3'h0);
    assign tgt_data_done = (cnt_reg == 3'h1) && !abort_mode;
    assign tgt_abort = (cnt_reg == 3'h1) && abort_mode;
    always_ff @(posedge mclk) begin
        if (srst) begin
            oe_reg <= 1'b0;
            cnt_reg <= 3'h0;
            sec_lock_busy <= 1'b0;
        end else begin
            oe_reg <= sec_lock_oe;
            // address phase, lock a clock later, then the data phase completes
            if (sec_lock_oe && !oe_reg) cnt_reg <= 3'h3;
            else if (cnt_reg != 3'h0) cnt_reg <= cnt_reg - 3'h1;
            // the other master locks only an idle bus whose lock is released
            sec_lock_busy <= other_lock && (sec_lock_busy || (sec_bus_idle && !sec_lock_oe));
        end
    end
endmodule : sec_bus_model

// file: tb/serr_lock_bridge_tb.sv
// self-checking bench of the bridge system-error and lock forwarding block
// assumes serr_lock_pkg, the design and sec_bus_model are compiled before it
module serr_lock_bridge_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import serr_lock_pkg::*;
    logic mclk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0, req_cmd = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic upstream_parity_error_line_n = 1'b1, downstream_parity_error_line_n = 1'b1;
    logic downstream_system_error_in_n = 1'b1, upstream_system_error_out_n;
    logic upstream_system_error_out_oe, pw_active = 1'b0, pw_upstream = 1'b0;
    logic pw_perr_as_target = 1'b0, pw_target_abort = 1'b0, pw_master_abort = 1'b0;
    logic txn_start = 1'b0, txn_retry = 1'b0, txn_done = 1'b0, dt_master_timeout = 1'b0;
    logic req_valid = 1'b0, req_lock = 1'b0, req_downstream = 1'b0;
    logic [35:0] req_key = 36'h123456789;
    logic head_is_locked = 1'b0, pri_lock_release = 1'b0, other_lock = 1'b0, abort_mode = 1'b0;
    logic sec_lock_busy, sec_bus_idle, tgt_data_done, tgt_abort, req_retry, req_master_abort;
    logic req_queue, req_give_data, req_give_abort, no_prefetch, discard;
    logic sec_lock_drive, sec_lock_oe;
    int num_errors = 0, n_compared = 0;

    serr_lock_bridge u_dut (.mclk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .upstream_parity_error_line_n, .downstream_parity_error_line_n,
        .downstream_system_error_in_n, .upstream_system_error_out_n,
        .upstream_system_error_out_oe, .pw_active, .pw_upstream, .pw_perr_as_target,
        .pw_target_abort, .pw_master_abort, .txn_start, .txn_retry, .txn_done,
        .dt_master_timeout, .req_valid, .req_lock, .req_downstream, .req_cmd, .req_key,
        .sec_lock_busy, .sec_bus_idle, .head_is_locked, .tgt_data_done, .tgt_abort,
        .pri_lock_release, .req_retry, .req_master_abort, .req_queue, .req_give_data,
        .req_give_abort, .no_prefetch, .discard, .sec_lock_drive, .sec_lock_oe);
    sec_bus_model u_sec (.mclk, .srst, .sec_lock_oe, .sec_lock_busy, .sec_bus_idle,
        .tgt_data_done, .tgt_abort, .other_lock, .abort_mode);

    always #12.5 mclk = ~mclk;

    // ----------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk) reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk) reg_rd <= 1'b0;
        @(negedge mclk) chk(what, exp, reg_rdata);
    endtask : rd

    task automatic clr;
        wr(OFS_PRI_STATUS, 32'h4000);
        wr(OFS_SEC_STATUS, 32'h4000);
        wr(OFS_CAUSE, 32'h3f);
    endtask : clr

    // chosen parity line low (upstream if lup) during a posted write, held past the pin synchroniser
    task automatic par(input logic up, input logic lup, input logic tgt, input logic exp,
                       input string what);
        @(posedge mclk);
        pw_active <= 1'b1;
        pw_upstream <= up;
        pw_perr_as_target <= tgt;
        upstream_parity_error_line_n <= !lup;
        downstream_parity_error_line_n <= lup;
        repeat (5) @(posedge mclk);
        @(negedge mclk) chk(what, 32'(exp), 32'(upstream_system_error_out_oe));
        @(posedge mclk);
        pw_active <= 1'b0;
        upstream_parity_error_line_n <= 1'b1;
        downstream_parity_error_line_n <= 1'b1;
        repeat (5) @(posedge mclk);
    endtask : par

    // e: {master timeout, master abort, target abort}, held three cycles
    task automatic evt(input logic [2:0] e, input logic exp, input string what);
        @(posedge mclk);
        pw_active <= |e[1:0];
        pw_target_abort <= e[0];
        pw_master_abort <= e[1];
        dt_master_timeout <= e[2];
        repeat (2) @(posedge mclk);
        @(negedge mclk) chk(what, 32'(exp), 32'(upstream_system_error_out_oe));
        @(posedge mclk);
        pw_active <= 1'b0;
        pw_target_abort <= 1'b0;
        pw_master_abort <= 1'b0;
        dt_master_timeout <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : evt

    // exp: {retry, master abort, queue, give data}, combinational in the request cycle
    task automatic req(input logic lk, input logic dn, input logic [3:0] cmd,
                       input logic [3:0] exp, input string what, input logic ab = 1'b0);
        @(posedge mclk);
        req_valid <= 1'b1;
        req_lock <= lk;
        req_downstream <= dn;
        req_cmd <= cmd;
        @(negedge mclk);
        chk(what, 32'({ab, exp}),
            32'({req_give_abort, req_retry, req_master_abort, req_queue, req_give_data}));
        @(posedge mclk) req_valid <= 1'b0;
    endtask : req

    task automatic wait_oe(input logic v, input string what);
        int n;
        n = 0;
        while (sec_lock_oe !== v && n < 20) begin
            @(negedge mclk);
            n++;
        end
        chk(what, 32'(v), 32'(sec_lock_oe));
    endtask : wait_oe

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        for (int i = 0; i < 6; i++) rd(4'(i), 32'h0, "reset value");
        rd(OFS_LOCK_STATUS, 32'(LK_IDLE), "reset lock state");
        rd(4'hf, 32'h0, "unmapped");
        chk("serr level", 32'h0, 32'(upstream_system_error_out_n));
        chk("sec lock level", 32'h0, 32'(sec_lock_drive));
    endtask : t_reset

    task automatic t_serr;
        wr(OFS_COMMAND, 32'h40);
        wr(OFS_BRIDGE_CTRL, 32'h1);
        par(1'b0, 1'b0, 1'b0, 1'b0, "serr disabled");
        wr(OFS_COMMAND, 32'h140);
        par(1'b0, 1'b0, 1'b1, 1'b0, "perr as target");
        par(1'b0, 1'b1, 1'b0, 1'b0, "near bus perr");
        par(1'b1, 1'b1, 1'b0, 1'b1, "upstream perr");
        par(1'b0, 1'b0, 1'b0, 1'b1, "downstream perr");
        rd(OFS_PRI_STATUS, 32'h4000, "signaled serr");
        rd(OFS_CAUSE, 32'h1, "cause parity");
        clr();
        wr(OFS_BRIDGE_CTRL, 32'h3);
        @(posedge mclk) downstream_system_error_in_n <= 1'b0;
        repeat (5) @(posedge mclk);
        @(negedge mclk) chk("fwd serr", 32'h1, 32'(upstream_system_error_out_oe));
        @(posedge mclk) downstream_system_error_in_n <= 1'b1;
        rd(OFS_SEC_STATUS, 32'h4000, "received serr");
        rd(OFS_CAUSE, 32'h20, "cause fwd");
        clr();
        evt(3'b100, 1'b0, "timeout disabled");
        wr(OFS_BRIDGE_CTRL, 32'h803);
        evt(3'b100, 1'b1, "timeout");
        wr(OFS_EVT_DISABLE, 32'h2);
        evt(3'b001, 1'b0, "abort masked");
        evt(3'b010, 1'b1, "master abort");
        wr(OFS_EVT_DISABLE, 32'h0);
        evt(3'b001, 1'b1, "target abort");
        rd(OFS_CAUSE, 32'h16, "cause events");
        clr();
    endtask : t_serr

    task automatic t_lock;
        logic [3:0] bad[5] = '{4'h2, 4'h3, 4'ha, 4'hb, 4'h7};
        foreach (bad[i]) req(1'b1, 1'b1, bad[i], 4'b0100, "bad first");
        @(posedge mclk) other_lock <= 1'b1;
        repeat (3) @(posedge mclk);
        req(1'b1, 1'b1, CMD_MEM_READ, 4'b1000, "target locked");
        @(posedge mclk) other_lock <= 1'b0;
        repeat (3) @(posedge mclk);
        req(1'b1, 1'b1, CMD_MEM_READ, 4'b0010, "lock queued");
        rd(OFS_LOCK_STATUS, 32'(LK_QUEUED), "queued state");
        req(1'b0, 1'b1, 4'h7, 4'b1000, "crossing retried");
        req(1'b1, 1'b0, CMD_MEM_READ, 4'b0010, "upstream unlocked");
        @(posedge mclk) other_lock <= 1'b1;
        @(posedge mclk) head_is_locked <= 1'b1;
        repeat (6) @(posedge mclk);
        @(negedge mclk) chk("wait for release", 32'h0, 32'(sec_lock_oe));
        @(posedge mclk) other_lock <= 1'b0;
        wait_oe(1'b1, "lock driven");
        repeat (6) @(posedge mclk);
        rd(OFS_LOCK_STATUS, 32'(LK_TARGET), "target state");
        @(posedge mclk) head_is_locked <= 1'b0;
        req(1'b1, 1'b1, CMD_MEM_READ, 4'b0001, "repeat read");
        rd(OFS_LOCK_STATUS, 32'(LK_HELD), "held state");
        chk("no prefetch", 32'h1, 32'(no_prefetch));
        req(1'b1, 1'b1, 4'h7, 4'b0010, "locked write");
        chk("lock kept", 32'h1, 32'(sec_lock_oe));
        @(posedge mclk) pri_lock_release <= 1'b1;
        @(posedge mclk) pri_lock_release <= 1'b0;
        wait_oe(1'b0, "lock released");
        rd(OFS_LOCK_STATUS, 32'(LK_IDLE), "idle state");
    endtask : t_lock

    task automatic t_abort;
        @(posedge mclk) abort_mode <= 1'b1;
        req(1'b1, 1'b1, CMD_MEM_READ, 4'b0010, "queue again");
        @(posedge mclk) head_is_locked <= 1'b1;
        wait_oe(1'b1, "lock driven");
        repeat (6) @(posedge mclk);
        rd(OFS_LOCK_STATUS, 32'(LK_IDLE), "abort state");
        wait_oe(1'b0, "abort lock off");
        req(1'b1, 1'b1, CMD_MEM_READ, 4'b0000, "abort returned", 1'b1);
        @(posedge mclk) abort_mode <= 1'b0;
        req(1'b1, 1'b1, CMD_MEM_READ, 4'b0010, "resume");
        wait_oe(1'b1, "lock driven");
        repeat (6) @(posedge mclk);
        @(posedge mclk) dt_master_timeout <= 1'b1;
        @(negedge mclk) chk("discard", 32'h1, 32'(discard));
        @(posedge mclk);
        dt_master_timeout <= 1'b0;
        head_is_locked <= 1'b0;
        wait_oe(1'b0, "timeout lock off");
        rd(OFS_LOCK_STATUS, 32'(LK_IDLE), "timeout state");
    endtask : t_abort

    task automatic end_sim;
        if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    initial begin
        repeat (5000) @(posedge mclk);
        num_errors++;
        end_sim();
    end

    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        repeat (3) @(posedge mclk);
        t_reset();
        t_serr();
        t_lock();
        t_abort();
        end_sim();
    end
endmodule : serr_lock_bridge_tb
